// ### uabg_regs.svh
// Purpose: offsets, fields, reset values and timing counts
// Assumes: 3-bit register address, 8-bit register data
// Notes: definitions only
`ifndef UABG_REGS_SVH
`define UABG_REGS_SVH

// register offsets
`define UABG_A_DATA 3'h0
`define UABG_A_DIV_LO 3'h1
`define UABG_A_DIV_HI 3'h2
`define UABG_A_LINE 3'h3
`define UABG_A_FIFO 3'h4
`define UABG_A_MODEM 3'h5
`define UABG_A_STATUS 3'h6
`define UABG_A_EVENT 3'h7

// line control fields
`define UABG_LC_WLEN 1:0
`define UABG_LC_STOP2 2
`define UABG_LC_PAREN 3
`define UABG_LC_EVEN 4
`define UABG_LC_BREAK 5
`define UABG_LC_OSM 6

// fifo control fields
`define UABG_FC_EN 0
`define UABG_FC_RXCLR 1
`define UABG_FC_TXCLR 2
`define UABG_FC_TRIG 4:3
`define UABG_FC_DMA 5

// modem control fields
`define UABG_MC_RTS 0
`define UABG_MC_LOOP 1
`define UABG_MC_AUTO 2
`define UABG_MC_SIMBRK 3
`define UABG_MC_SIMPAR 4
`define UABG_MC_SIMFRM 5
`define UABG_MC_SIMOVR 6

// event enable fields
`define UABG_EV_RX 0
`define UABG_EV_TX 1

// reset values
`define UABG_RST_BYTE 8'h00
`define UABG_RST_LINE 8'h03
`define UABG_RST_DIV 16'h0000

// timing counts
`define UABG_PRE_LAST 3'h5
`define UABG_OS16 6'h10
`define UABG_OS13 6'h0D
`define UABG_SAMP16 6'h07
`define UABG_SAMP13 6'h06
`define UABG_RELOAD_WAIT 2'h2
`define UABG_WLEN_BASE 3'h4
`define UABG_WLEN_MAX 2'h3

// receive fifo trigger levels
`define UABG_TRIG0 8'h01
`define UABG_TRIG1 8'h04
`define UABG_TRIG2 8'h08
`define UABG_TRIG3 8'h0E

`endif

// ### uabg_pkg.sv
// Purpose: shared types of the uart core
// Assumes: nothing
// Notes: types only
package uabg_pkg;

    // serial frame phases
    typedef enum logic [2:0] {
        UABG_IDLE,
        UABG_START,
        UABG_DATA,
        UABG_PAR,
        UABG_STOP
    } uabg_phase_e;

endpackage

// ### uabg_core.sv
// Purpose: uart core with baud generator and fifos
// Assumes: sys_clk_i is the cpu clock
// Notes: pin levels are logical, 1 = mark / asserted
// Function
// - baud divisor 1 to 65535 divides input clock
// - each bit spans 16 or 13 baud ticks
// - 16x receive samples on eighth baud tick
// - divisor held in high and low bytes
// - divisor write: two-cycle generator reload
// - module input clock is cpu clock divided six
// - module clock gated until enabled
// - starts unbuffered, fifo mode selectable
// - 16-byte fifos, three error bits per rx
// - character length 5 to 8 bits
// - even, odd or no parity both ways
// - stop period 1, 1.5 or 2 bits
// - rx trigger 1, 4, 8, 14 bytes
// - separate rx and tx dma requests
// - no single-character dma, fifo mode only
// - rx and tx interrupt requests
// - false start bit returns receiver to idle
// - send break, detect and flag break
// - loopback routes transmitter into receiver
// - simulate break, parity, overrun, framing errors
// - autoflow drops rts, holds tx on cts
// - drives tx and rts, takes rx, cts
// - receiver checks only the first stop bit
//
// Local design decisions: strobed register access and the address map.
`include "uabg_regs.svh"

module uabg_core #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // from the power_sleep_controller
    input wire logic clk_enable_i,
    // serial pins
    input wire logic serial_rx_line_i,
    input wire logic clear_to_send_in_i,
    output logic serial_tx_line_o,
    output logic request_to_send_out_o,
    // events
    output logic rx_irq_o,
    output logic tx_irq_o,
    output logic rx_dma_req_o,
    output logic tx_dma_req_o,
    output logic div_reload_busy_o
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [7:0] div_lo, div_hi, line_ctrl, fifo_ctrl, modem_ctrl, ev_en;
    logic [15:0] divisor;
    logic fifo_en, loop_en, auto_en, par_en, even_par, osm;
    logic [1:0] wlen;
    logic [2:0] last_bit;
    logic [5:0] os_len, os_last, samp_idx, stop_len;
    logic [CW-1:0] limit, trig, rx_cnt;

    // rx trigger level
    function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
        logic [7:0] lvl;
        lvl = `UABG_TRIG0;
        unique case (sel)
            2'h0: lvl = `UABG_TRIG0;
            2'h1: lvl = `UABG_TRIG1;
            2'h2: lvl = `UABG_TRIG2;
            2'h3: lvl = `UABG_TRIG3;
        endcase
        return CW'(lvl);
    endfunction

    // parity of the active bits
    function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl, input logic even);
        logic [7:0] m;
        m = d & (8'hFF >> (`UABG_WLEN_MAX - wl));
        return even ? ^m : ~^m;
    endfunction

    assign divisor = {div_hi, div_lo};
    assign fifo_en = fifo_ctrl[`UABG_FC_EN];
    assign loop_en = modem_ctrl[`UABG_MC_LOOP];
    assign auto_en = modem_ctrl[`UABG_MC_AUTO];
    assign par_en = line_ctrl[`UABG_LC_PAREN];
    assign even_par = line_ctrl[`UABG_LC_EVEN];
    assign osm = line_ctrl[`UABG_LC_OSM];
    assign wlen = line_ctrl[`UABG_LC_WLEN];
    assign last_bit = 3'(wlen) + `UABG_WLEN_BASE;
    assign os_len = osm ? `UABG_OS13 : `UABG_OS16;
    assign os_last = os_len - 6'h01;
    assign samp_idx = osm ? `UABG_SAMP13 : `UABG_SAMP16;
    // 1.5 stop bits only for 5-bit characters
    assign stop_len = !line_ctrl[`UABG_LC_STOP2] ? os_len :
                      (wlen == 2'h0) ? os_len + (os_len >> 1) : os_len << 1;
    assign limit = fifo_en ? CW'(DEPTH) : CW'(1);
    assign trig = trig_level(fifo_ctrl[`UABG_FC_TRIG]);

    // bus decode
    logic wr_data, rd_data, wr_div, rd_status, fifo_change, tx_clr, rx_clr;
    assign wr_data = reg_wr_i && reg_addr_i == `UABG_A_DATA;
    assign rd_data = reg_rd_i && reg_addr_i == `UABG_A_DATA;
    assign rd_status = reg_rd_i && reg_addr_i == `UABG_A_STATUS;
    assign wr_div = reg_wr_i && (reg_addr_i == `UABG_A_DIV_LO || reg_addr_i == `UABG_A_DIV_HI);
    assign fifo_change = reg_wr_i && reg_addr_i == `UABG_A_FIFO
                         && reg_wdata_i[`UABG_FC_EN] != fifo_en;
    assign tx_clr = fifo_change || (reg_wr_i && reg_addr_i == `UABG_A_FIFO && reg_wdata_i[`UABG_FC_TXCLR]);
    assign rx_clr = fifo_change || (reg_wr_i && reg_addr_i == `UABG_A_FIFO && reg_wdata_i[`UABG_FC_RXCLR]);

    // control registers; fifo clear bits self-clear
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            div_lo <= `UABG_RST_BYTE;
            div_hi <= `UABG_RST_BYTE;
            line_ctrl <= `UABG_RST_LINE;
            fifo_ctrl <= `UABG_RST_BYTE;
            modem_ctrl <= `UABG_RST_BYTE;
            ev_en <= `UABG_RST_BYTE;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                `UABG_A_DIV_LO: div_lo <= reg_wdata_i;
                `UABG_A_DIV_HI: div_hi <= reg_wdata_i;
                `UABG_A_LINE: line_ctrl <= reg_wdata_i;
                `UABG_A_FIFO: fifo_ctrl <= reg_wdata_i & ~8'h06;
                `UABG_A_MODEM: modem_ctrl <= reg_wdata_i;
                `UABG_A_EVENT: ev_en <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // module clock: cpu clock / 6, prescaler cleared and stopped while gated
    logic [2:0] pre_cnt;
    logic mod_ce;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !clk_enable_i)
        begin
            pre_cnt <= 3'h0;
            mod_ce <= 1'b0;
        end
        else if (pre_cnt == `UABG_PRE_LAST)
        begin
            pre_cnt <= 3'h0;
            mod_ce <= 1'b1;
        end
        else
        begin
            pre_cnt <= pre_cnt + 3'h1;
            mod_ce <= 1'b0;
        end
    end

    // baud generator; divisor 0 stops ticks, no divide by 65536
    logic [15:0] baud_cnt;
    logic [1:0] reload_cnt;
    logic bclk;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            baud_cnt <= `UABG_RST_DIV;
            reload_cnt <= 2'h0;
            bclk <= 1'b0;
        end
        else
        begin
            bclk <= 1'b0;
            if (wr_div)
                reload_cnt <= `UABG_RELOAD_WAIT;
            else if (reload_cnt != 2'h0)
            begin
                reload_cnt <= reload_cnt - 2'h1;
                baud_cnt <= divisor;
            end
            else if (mod_ce && divisor != 16'h0000)
            begin
                if (baud_cnt <= 16'h0001)
                begin
                    baud_cnt <= divisor;
                    bclk <= 1'b1;
                end
                else
                    baud_cnt <= baud_cnt - 16'h0001;
            end
        end
    end
    assign div_reload_busy_o = reload_cnt != 2'h0;

    // transmit fifo
    logic [7:0] tx_mem [DEPTH];
    logic [PW-1:0] tx_wp, tx_rp;
    logic [CW-1:0] tx_cnt;
    logic tx_push, tx_pop;
    assign tx_push = wr_data && tx_cnt < limit; // full: the write is dropped
    always_ff @(posedge sys_clk_i)
    begin
        if (tx_push)
            tx_mem[tx_wp] <= reg_wdata_i;
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || tx_clr)
        begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wp <= PW'(tx_wp + 1'b1);
            if (tx_pop)
                tx_rp <= PW'(tx_rp + 1'b1);
            tx_cnt <= CW'(tx_cnt + CW'(tx_push) - CW'(tx_pop));
        end
    end

    // transmitter
    uabg_pkg::uabg_phase_e tx_st;
    logic [7:0] tx_shift;
    logic [5:0] tx_os;
    logic [2:0] tx_bit;
    logic tx_par, tx_line, rts_int, cts_eff;
    assign cts_eff = loop_en ? rts_int : clear_to_send_in_i;
    assign tx_pop = bclk && tx_st == uabg_pkg::UABG_IDLE && tx_cnt != '0
                    && (!auto_en || cts_eff);
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_st <= uabg_pkg::UABG_IDLE;
            tx_shift <= 8'h00;
            tx_os <= 6'h00;
            tx_bit <= 3'h0;
            tx_par <= 1'b0;
            tx_line <= 1'b1;
        end
        else if (bclk)
        begin
            tx_os <= tx_os + 6'h01;
            unique case (tx_st)
                uabg_pkg::UABG_IDLE:
                    if (tx_pop)
                    begin
                        tx_shift <= tx_mem[tx_rp];
                        tx_par <= par_of(tx_mem[tx_rp], wlen, even_par);
                        tx_line <= 1'b0;
                        tx_os <= 6'h00;
                        tx_st <= uabg_pkg::UABG_START;
                    end
                uabg_pkg::UABG_START:
                    if (tx_os == os_last)
                    begin
                        tx_os <= 6'h00;
                        tx_bit <= 3'h0;
                        tx_line <= tx_shift[0];
                        tx_st <= uabg_pkg::UABG_DATA;
                    end
                uabg_pkg::UABG_DATA:
                    if (tx_os == os_last)
                    begin
                        tx_os <= 6'h00;
                        tx_shift <= tx_shift >> 1;
                        tx_bit <= tx_bit + 3'h1;
                        tx_line <= tx_shift[1];
                        if (tx_bit == last_bit)
                        begin
                            tx_line <= par_en ? tx_par : 1'b1;
                            tx_st <= par_en ? uabg_pkg::UABG_PAR : uabg_pkg::UABG_STOP;
                        end
                    end
                uabg_pkg::UABG_PAR:
                    if (tx_os == os_last)
                    begin
                        tx_os <= 6'h00;
                        tx_line <= 1'b1;
                        tx_st <= uabg_pkg::UABG_STOP;
                    end
                uabg_pkg::UABG_STOP:
                    if (tx_os == stop_len - 6'h01)
                        tx_st <= uabg_pkg::UABG_IDLE;
            endcase
        end
    end

    // pins; loopback holds tx marking, rts off
    logic tx_int;
    assign tx_int = tx_line && !line_ctrl[`UABG_LC_BREAK];
    assign rts_int = modem_ctrl[`UABG_MC_RTS] && (!auto_en || rx_cnt < trig);
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            serial_tx_line_o <= 1'b1;
            request_to_send_out_o <= 1'b0;
        end
        else
        begin
            serial_tx_line_o <= loop_en ? 1'b1 : tx_int;
            request_to_send_out_o <= !loop_en && rts_int;
        end
    end

    // receive fifo: {break, framing, parity, character}
    logic [10:0] rx_mem [DEPTH];
    logic [PW-1:0] rx_wp, rx_rp;
    logic [10:0] rx_entry, rx_head;
    logic rx_done, rx_push, rx_pop, overrun;
    assign rx_push = rx_done && rx_cnt < limit;
    assign rx_pop = rd_data && rx_cnt != '0;
    assign rx_head = rx_cnt != '0 ? rx_mem[rx_rp] : 11'h000;
    always_ff @(posedge sys_clk_i)
    begin
        if (rx_push)
            rx_mem[rx_wp] <= rx_entry;
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || rx_clr)
        begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wp <= PW'(rx_wp + 1'b1);
            if (rx_pop)
                rx_rp <= PW'(rx_rp + 1'b1);
            rx_cnt <= CW'(rx_cnt + CW'(rx_push) - CW'(rx_pop));
        end
    end

    // overrun is sticky; a new overrun wins over the clearing status read
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            overrun <= 1'b0;
        else if (rx_done && (rx_cnt >= limit || modem_ctrl[`UABG_MC_SIMOVR]))
            overrun <= 1'b1;
        else if (rd_status)
            overrun <= 1'b0;
    end

    // receiver
    uabg_pkg::uabg_phase_e rx_st;
    logic [7:0] rx_shift, rx_char;
    logic [5:0] rx_os;
    logic [2:0] rx_bit;
    logic rx_in, rx_prev, rx_pbit, pe, fe, brk;
    assign rx_in = loop_en ? tx_int : serial_rx_line_i;
    assign rx_char = rx_shift >> (`UABG_WLEN_MAX - wlen);
    assign fe = !rx_in || modem_ctrl[`UABG_MC_SIMFRM] || modem_ctrl[`UABG_MC_SIMBRK];
    assign brk = (!rx_in && rx_char == 8'h00 && !(par_en && rx_pbit))
                 || modem_ctrl[`UABG_MC_SIMBRK];
    assign pe = (par_en && rx_pbit != par_of(rx_char, wlen, even_par))
                || modem_ctrl[`UABG_MC_SIMPAR];
    assign rx_entry = {brk, fe, pe, rx_char};
    assign rx_done = bclk && rx_st == uabg_pkg::UABG_STOP && rx_os == samp_idx;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rx_st <= uabg_pkg::UABG_IDLE;
            rx_shift <= 8'h00;
            rx_os <= 6'h00;
            rx_bit <= 3'h0;
            rx_pbit <= 1'b0;
            rx_prev <= 1'b1;
        end
        else if (bclk)
        begin
            rx_prev <= rx_in; // a held-low break cannot restart a frame
            rx_os <= rx_os + 6'h01;
            unique case (rx_st)
                uabg_pkg::UABG_IDLE:
                    if (rx_prev && !rx_in)
                    begin
                        rx_os <= 6'h01;
                        rx_st <= uabg_pkg::UABG_START;
                    end
                uabg_pkg::UABG_START:
                    if (rx_os == samp_idx && rx_in)
                        rx_st <= uabg_pkg::UABG_IDLE;
                    else if (rx_os == os_last)
                    begin
                        rx_os <= 6'h00;
                        rx_bit <= 3'h0;
                        rx_st <= uabg_pkg::UABG_DATA;
                    end
                uabg_pkg::UABG_DATA:
                begin
                    if (rx_os == samp_idx)
                        rx_shift <= {rx_in, rx_shift[7:1]};
                    if (rx_os == os_last)
                    begin
                        rx_os <= 6'h00;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == last_bit)
                            rx_st <= par_en ? uabg_pkg::UABG_PAR : uabg_pkg::UABG_STOP;
                    end
                end
                uabg_pkg::UABG_PAR:
                begin
                    if (rx_os == samp_idx)
                        rx_pbit <= rx_in;
                    if (rx_os == os_last)
                    begin
                        rx_os <= 6'h00;
                        rx_st <= uabg_pkg::UABG_STOP;
                    end
                end
                uabg_pkg::UABG_STOP:
                    if (rx_os == samp_idx)
                        rx_st <= uabg_pkg::UABG_IDLE;
            endcase
        end
    end

    // dma and interrupt requests; dma only in fifo mode
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rx_dma_req_o <= 1'b0;
            tx_dma_req_o <= 1'b0;
            rx_irq_o <= 1'b0;
            tx_irq_o <= 1'b0;
        end
        else
        begin
            rx_dma_req_o <= fifo_en && fifo_ctrl[`UABG_FC_DMA] && rx_cnt >= trig;
            tx_dma_req_o <= fifo_en && fifo_ctrl[`UABG_FC_DMA] && tx_cnt == '0;
            rx_irq_o <= ev_en[`UABG_EV_RX] && (fifo_en ? rx_cnt >= trig : rx_cnt != '0);
            tx_irq_o <= ev_en[`UABG_EV_TX] && tx_cnt == '0;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `UABG_A_DATA: reg_rdata_o <= rx_head[7:0];
                `UABG_A_DIV_LO: reg_rdata_o <= div_lo;
                `UABG_A_DIV_HI: reg_rdata_o <= div_hi;
                `UABG_A_LINE: reg_rdata_o <= line_ctrl;
                `UABG_A_FIFO: reg_rdata_o <= fifo_ctrl;
                `UABG_A_MODEM: reg_rdata_o <= modem_ctrl;
                `UABG_A_STATUS: reg_rdata_o <= {1'b0, tx_st == uabg_pkg::UABG_IDLE && tx_cnt == '0,
                    tx_cnt == '0, rx_head[10:8], overrun, rx_cnt != '0};
                `UABG_A_EVENT: reg_rdata_o <= ev_en;
            endcase
        end
    end

endmodule

// ### uabg_checker.sv
// Purpose: port checks of the uart core
// Assumes: bound to uabg_core, one clock
// Notes: bit length is checked at divisor 1 only
`include "uabg_regs.svh"
module uabg_checker (
    // clock and register port
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic clk_enable_i,
    // watched outputs
    input wire logic serial_tx_line_o,
    input wire logic request_to_send_out_o,
    input wire logic rx_irq_o,
    input wire logic rx_dma_req_o,
    input wire logic tx_dma_req_o,
    input wire logic div_reload_busy_o
);
    logic [15:0] div, low_cnt;
    logic osm, loop, fen, div_wr;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // either latch byte starts a reload
    assign div_wr = reg_wr_i && reg_addr_i inside {`UABG_A_DIV_LO, `UABG_A_DIV_HI};
    // shadow of control bits
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            div <= `UABG_RST_DIV;
            {osm, loop, fen} <= 3'h0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `UABG_A_DIV_LO: div[7:0] <= reg_wdata_i;
                `UABG_A_DIV_HI: div[15:8] <= reg_wdata_i;
                `UABG_A_LINE: osm <= reg_wdata_i[`UABG_LC_OSM];
                `UABG_A_FIFO: fen <= reg_wdata_i[`UABG_FC_EN];
                `UABG_A_MODEM: loop <= reg_wdata_i[`UABG_MC_LOOP];
                default: ;
            endcase
        end
    end
    // tx low run length, whole bits except under break or clock gating
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || serial_tx_line_o)
            low_cnt <= 16'h0000;
        else
            low_cnt <= low_cnt + 16'h0001;
    end
    busy_start_a: assert property (div_wr |=> div_reload_busy_o [*2])
        else $error("reload wait too short");
    busy_end_a: assert property (div_wr ##1 !div_wr [*2] |=> !div_reload_busy_o)
        else $error("reload wait too long");
    busy_cause_a: assert property ($rose(div_reload_busy_o) |-> $past(div_wr))
        else $error("reload wait without divisor write");
    reset_pins_a: assert property ($fell(rst_i) |-> serial_tx_line_o && !request_to_send_out_o && !rx_irq_o)
        else $error("pins not idle after reset");
    bit_len_a: assert property ($rose(serial_tx_line_o) && div == 16'h0001
        |-> low_cnt % (osm ? 16'h004E : 16'h0060) == 16'h0000)
        else $error("tx low run not whole bits");
    loop_pins_a: assert property (loop && $past(loop) |-> serial_tx_line_o && !request_to_send_out_o)
        else $error("pins active in loopback");
    dma_fifo_a: assert property (!fen && !$past(fen) |-> !rx_dma_req_o && !tx_dma_req_o)
        else $error("dma request outside fifo mode");
    gate_a: assert property (!clk_enable_i && !$past(clk_enable_i) |-> $stable(serial_tx_line_o))
        else $error("tx moved with clock gated");
    // main scenarios reached
    cover property ($fell(serial_tx_line_o));
    cover property (rx_irq_o);
    cover property (tx_dma_req_o);
endmodule
bind uabg_core uabg_checker uabg_checker_inst (.*);

// ### uabg_far_end.sv
// Purpose: far-end serial device
// Assumes: bit length given in clock cycles
// Notes: holds its line at mark between frames
module uabg_far_end (
    // clock
    input wire logic sys_clk_i,
    // serial pins
    input wire logic tx_i,
    output logic rx_o,
    output logic cts_o
);
    // idle mark, ready
    initial
    begin
        rx_o = 1'b1;
        cts_o = 1'b1;
    end
    // start, n bits lsb first, one stop
    task automatic send(input logic [8:0] bits, input int n, input int bl);
        rx_o <= 1'b0;
        repeat (bl) @(posedge sys_clk_i);
        for (int i = 0; i < n; i++)
        begin
            rx_o <= bits[i];
            repeat (bl) @(posedge sys_clk_i);
        end
        rx_o <= 1'b1;
        repeat (bl) @(posedge sys_clk_i);
    endtask
    // mid-bit sampling; bounded wait on a dead line
    task automatic capture(output logic [8:0] bits, input int n, input int bl, output logic ok);
        int t;
        bits = 9'h000;
        t = 0;
        while (tx_i && t < 20000)
        begin
            @(posedge sys_clk_i);
            t++;
        end
        repeat (bl / 2) @(posedge sys_clk_i);
        ok = !tx_i;
        for (int i = 0; i < n; i++)
        begin
            repeat (bl) @(posedge sys_clk_i);
            bits[i] = tx_i;
        end
        repeat (bl) @(posedge sys_clk_i);
        ok = ok && tx_i;
    endtask
endmodule

// ### uabg_core_tb.sv
// Purpose: self-checking bench of the uart core
// Assumes: divisor 1, so a bit is 96 clocks at 16x and 78 at 13x
// Notes: uabg_far_end plays the remote device
`include "uabg_regs.svh"
module uabg_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] ST = `UABG_A_STATUS;
    localparam logic [2:0] DT = `UABG_A_DATA;
    localparam logic [2:0] MD = `UABG_A_MODEM;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic clk_enable_i = 1'b1;
    logic [7:0] reg_rdata_o;
    logic rx, cts, tx, rts, rx_irq, tx_irq, rx_dma, tx_dma, ok;
    logic [8:0] got;
    int bad_count = 0;
    int tests_run = 0;
    // design and remote device
    uabg_core #(.DEPTH(16)) uabg_core_inst (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .clk_enable_i, .serial_rx_line_i(rx), .clear_to_send_in_i(cts),
        .serial_tx_line_o(tx), .request_to_send_out_o(rts), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq),
        .rx_dma_req_o(rx_dma), .tx_dma_req_o(tx_dma), .div_reload_busy_o());
    uabg_far_end uabg_far_end_inst (.sys_clk_i, .tx_i(tx), .rx_o(rx), .cts_o(cts));
    // 10 MHz clock
    always #50 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data stand one cycle after the strobe
    task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(what, {1'b0, reg_rdata_o}, {1'b0, exp});
    endtask
    // reset values, then divisor 1: 10 MHz / 6 / 16 per bit
    task automatic t_regs();
        rchk("line", `UABG_A_LINE, 8'h03);
        rchk("fifo", `UABG_A_FIFO, 8'h00);
        rchk("status", ST, 8'h60);
        wr(`UABG_A_DIV_LO, 8'h01);
        wr(`UABG_A_DIV_HI, 8'h00);
        rchk("div lo", `UABG_A_DIV_LO, 8'h01);
        rchk("div hi", `UABG_A_DIV_HI, 8'h00);
    endtask
    // 8E1, 7O1 at 13x, 5N1
    task automatic t_tx();
        logic [7:0] lc [3] = '{8'h1B, 8'h4A, 8'h00};
        logic [8:0] exp;
        int n;
        int bl;
        for (int i = 0; i < 3; i++)
        begin
            n = lc[i][1:0] + 5;
            bl = lc[i][6] ? 78 : 96;
            exp = 9'h0A5 & ((9'h001 << n) - 9'h001);
            exp[n] = lc[i][3] & (^exp ^ !lc[i][4]);
            wr(`UABG_A_LINE, lc[i]);
            wr(DT, 8'hA5);
            uabg_far_end_inst.capture(got, n + lc[i][3], bl, ok);
            chk("tx frame", got, exp);
            chk("tx framing", ok, 1'b1);
            cyc(bl);
        end
    endtask
    // false start, good, parity, break, simulated errors
    task automatic t_rx();
        wr(`UABG_A_LINE, 8'h1B);
        wr(`UABG_A_EVENT, 8'h03);
        uabg_far_end_inst.rx_o <= 1'b0;
        cyc(30);
        uabg_far_end_inst.rx_o <= 1'b1;
        cyc(200);
        rchk("false start", ST, 8'h60);
        uabg_far_end_inst.send(9'h03C, 9, 96);
        cyc(2);
        #1 chk("rx irq", rx_irq, 1'b1);
        chk("tx irq", tx_irq, 1'b1);
        rchk("rx ok", ST, 8'h61);
        rchk("rx char", DT, 8'h3C);
        uabg_far_end_inst.send(9'h13C, 9, 96);
        rchk("rx parity", ST, 8'h65);
        rchk("rx char", DT, 8'h3C);
        uabg_far_end_inst.rx_o <= 1'b0;
        cyc(1200);
        uabg_far_end_inst.rx_o <= 1'b1;
        cyc(200);
        rchk("rx break", ST, 8'h79);
        rchk("break char", DT, 8'h00);
        wr(MD, 8'h50);
        uabg_far_end_inst.send(9'h03C, 9, 96);
        rchk("rx sim", ST, 8'h67);
        rchk("sim char", DT, 8'h3C);
        wr(MD, 8'h00);
    endtask
    // autoflow: tx held while cts low
    task automatic t_flow();
        wr(`UABG_A_LINE, 8'h03);
        wr(MD, 8'h05);
        uabg_far_end_inst.cts_o <= 1'b0;
        wr(DT, 8'h81);
        cyc(300);
        #1 chk("tx held", tx, 1'b1);
        chk("rts", rts, 1'b1);
        chk("tx irq busy", tx_irq, 1'b0);
        uabg_far_end_inst.cts_o <= 1'b1;
        uabg_far_end_inst.capture(got, 8, 96, ok);
        chk("tx after cts", got, 9'h081);
        cyc(100);
        wr(MD, 8'h00);
    endtask
    // loopback
    task automatic t_loop();
        wr(MD, 8'h02);
        wr(DT, 8'h5A);
        cyc(1200);
        rchk("loop status", ST, 8'h61);
        rchk("loop char", DT, 8'h5A);
        wr(MD, 8'h00);
    endtask
    // clock gating, then fifo-mode dma
    task automatic t_gate_dma();
        clk_enable_i <= 1'b0;
        wr(DT, 8'h33);
        cyc(300);
        #1 chk("gated tx", tx, 1'b1);
        clk_enable_i <= 1'b1;
        uabg_far_end_inst.capture(got, 8, 96, ok);
        chk("ungated tx", got, 9'h033);
        cyc(100);
        wr(`UABG_A_FIFO, 8'h21);
        cyc(3);
        #1 chk("tx dma", tx_dma, 1'b1);
        chk("rx dma idle", rx_dma, 1'b0);
        uabg_far_end_inst.send(9'h003, 8, 96);
        cyc(2);
        #1 chk("rx dma", rx_dma, 1'b1);
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // 6-cycle reset, then the scenarios
    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_tx();
        t_rx();
        t_flow();
        t_loop();
        t_gate_dma();
        print_verdict();
    end
    // watchdog, past the ~12400 cycles needed
    initial
    begin
        repeat (40000) @(posedge sys_clk_i);
        bad_count++;
        print_verdict();
    end
endmodule
